// *** rtl/scgs_sequencer.sv ***
`timescale 1ns/1ps
// Functional notes
// - Sub command honoured only with permitting main
// - All-sub main codes accept all eight subs
// - Listed mains accept only no-op and monitor
// - Connect and disconnect accept only no-op
// - Same timing for communication or transmission cycle
// - Connect opens link and starts watchdog
// - Identity read then parameter read answered
// - Written parameters take effect on apply
// - Encoder power-up precedes servo enable
// - Amplifier-managed flow stores parameters in flash
// - Decode the eight sub command codes
module scgs_sequencer #(
	parameter int WDT_CYCLES = scgs_pkg::WDT_CYCLES_DEFAULT
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic cycle_tick_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] main_code_in,
	input wire logic [7:0] sub_code_in,
	input wire logic init_done_in,
	input wire logic amp_managed_in,
	output logic resp_valid_out,
	output logic [7:0] resp_main_out,
	output logic [7:0] resp_sub_out,
	output logic [scgs_pkg::ST_WIDTH-1:0] resp_status_out,
	output logic main_exec_out,
	output logic sub_exec_out,
	output logic identity_read_out,
	output logic param_read_out,
	output logic param_stage_out,
	output logic param_apply_out,
	output logic flash_store_out,
	output logic connected_out,
	output logic encoder_power_out,
	output logic servo_on_out,
	output logic wdt_alarm_out
);
	typedef struct packed {
		logic resp_valid;
		logic [7:0] resp_main;
		logic [7:0] resp_sub;
		logic main_exec;
		logic sub_exec;
		logic identity_read;
		logic param_read;
		logic param_stage;
		logic param_apply;
		logic flash_store;
		logic connected;
		logic encoder_on;
		logic servo_on;
		logic param_pending;
		logic cmd_error;
		logic seq_error;
		logic wdt_alarm;
		logic init_done;
		logic [scgs_pkg::WDT_WIDTH-1:0] wdt_cnt;
	} scgs_state_t;

	localparam logic [scgs_pkg::WDT_WIDTH-1:0] WDT_LIMIT =
		scgs_pkg::WDT_WIDTH'(WDT_CYCLES);

	scgs_state_t state_reg;
	scgs_state_t state_next;
	scgs_decode_if dec ();

	assign dec.main_code = main_code_in;
	assign dec.sub_code = sub_code_in;

	scgs_permit_decoder u_decoder (
		.dec(dec)
	);

	////////////////////////////////////////////////////////////////////
	logic is_motion;
	logic main_ok;
	logic param_write;
	logic sub_param_write;

	always_comb begin
		is_motion = (main_code_in == scgs_pkg::MAIN_INTERPOLATE) ||
			(main_code_in == scgs_pkg::MAIN_POSITIONING_MOVE) ||
			(main_code_in == scgs_pkg::MAIN_FEED) ||
			(main_code_in == scgs_pkg::MAIN_LATCHED_FEED) ||
			(main_code_in == scgs_pkg::MAIN_LATCHED_POSITIONING) ||
			(main_code_in == scgs_pkg::MAIN_ORIGIN_RETURN) ||
			(main_code_in == scgs_pkg::MAIN_VELOCITY_CONTROL) ||
			(main_code_in == scgs_pkg::MAIN_TORQUE_CONTROL);
		// Only no-op, connect and disconnect work without a connection
		main_ok = (dec.main_class != scgs_pkg::SCGS_CLASS_UNKNOWN) &&
			(state_reg.connected ||
			(main_code_in == scgs_pkg::MAIN_NOP) ||
			(main_code_in == scgs_pkg::MAIN_CONNECT) ||
			(main_code_in == scgs_pkg::MAIN_DISCONNECT));
		if (is_motion && !state_reg.servo_on) begin
			main_ok = 1'b0;
		end
		if ((main_code_in == scgs_pkg::MAIN_SERVO_ENABLE) &&
			!state_reg.encoder_on) begin
			main_ok = 1'b0;
		end
		param_write = main_ok &&
			(main_code_in == scgs_pkg::MAIN_SERVO_PARAM_WRITE);
		sub_param_write = dec.sub_allowed &&
			(sub_code_in == scgs_pkg::SUB_SERVO_PARAM_WRITE);
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.resp_valid = 1'b0;
		state_next.main_exec = 1'b0;
		state_next.sub_exec = 1'b0;
		state_next.identity_read = 1'b0;
		state_next.param_read = 1'b0;
		state_next.param_stage = 1'b0;
		state_next.param_apply = 1'b0;
		state_next.flash_store = 1'b0;
		// Init-done reaches the status a cycle late, like every other bit
		state_next.init_done = init_done_in;

		// Watchdog counts cycles with no command while connected
		if (state_reg.connected) begin
			if (cmd_valid_in) begin
				state_next.wdt_cnt = '0;
			end else if (cycle_tick_in) begin
				state_next.wdt_cnt = state_reg.wdt_cnt + 1'b1;
			end
			if (cycle_tick_in && !cmd_valid_in &&
				(state_reg.wdt_cnt >= WDT_LIMIT - 1'b1)) begin
				state_next.wdt_alarm = 1'b1;
				state_next.connected = 1'b0;
				state_next.servo_on = 1'b0;
			end
		end

		// Same one-cycle answer whichever cycle paces the command
		if (cmd_valid_in) begin
			state_next.resp_valid = 1'b1;
			state_next.resp_main = main_code_in;
			state_next.resp_sub = sub_code_in;
			state_next.main_exec = main_ok;
			state_next.sub_exec = dec.sub_allowed;
			state_next.cmd_error = !dec.sub_allowed ||
				(dec.main_class == scgs_pkg::SCGS_CLASS_UNKNOWN);
			state_next.seq_error = !main_ok &&
				(dec.main_class != scgs_pkg::SCGS_CLASS_UNKNOWN);
			if (main_ok) begin
				unique case (main_code_in)
					scgs_pkg::MAIN_CONNECT: begin
						state_next.connected = 1'b1;
						state_next.wdt_cnt = '0;
						state_next.wdt_alarm = 1'b0;
					end
					scgs_pkg::MAIN_DISCONNECT: begin
						state_next.connected = 1'b0;
						state_next.servo_on = 1'b0;
					end
					scgs_pkg::MAIN_IDENTITY_READ: begin
						state_next.identity_read = 1'b1;
					end
					scgs_pkg::MAIN_SERVO_PARAM_READ: begin
						state_next.param_read = 1'b1;
					end
					scgs_pkg::MAIN_CONFIG_APPLY: begin
						state_next.param_apply = 1'b1;
						state_next.param_pending = 1'b0;
					end
					scgs_pkg::MAIN_ENCODER_POWER_UP: begin
						state_next.encoder_on = 1'b1;
					end
					scgs_pkg::MAIN_ENCODER_POWER_DOWN: begin
						state_next.encoder_on = 1'b0;
						state_next.servo_on = 1'b0;
					end
					scgs_pkg::MAIN_SERVO_ENABLE: begin
						state_next.servo_on = 1'b1;
					end
					scgs_pkg::MAIN_SERVO_DISABLE: begin
						state_next.servo_on = 1'b0;
					end
					default: begin
					end
				endcase
			end
			if (dec.sub_allowed &&
				(sub_code_in == scgs_pkg::SUB_SERVO_PARAM_READ)) begin
				state_next.param_read = 1'b1;
			end
			// Written values are held back until apply, or go to flash
			if (param_write || sub_param_write) begin
				if (amp_managed_in) begin
					state_next.flash_store = 1'b1;
				end else begin
					state_next.param_stage = 1'b1;
					state_next.param_pending = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign resp_valid_out = state_reg.resp_valid;
	assign resp_main_out = state_reg.resp_main;
	assign resp_sub_out = state_reg.resp_sub;
	assign main_exec_out = state_reg.main_exec;
	assign sub_exec_out = state_reg.sub_exec;
	assign identity_read_out = state_reg.identity_read;
	assign param_read_out = state_reg.param_read;
	assign param_stage_out = state_reg.param_stage;
	assign param_apply_out = state_reg.param_apply;
	assign flash_store_out = state_reg.flash_store;
	assign connected_out = state_reg.connected;
	assign encoder_power_out = state_reg.encoder_on;
	assign servo_on_out = state_reg.servo_on;
	assign wdt_alarm_out = state_reg.wdt_alarm;

	always_comb begin
		resp_status_out = '0;
		resp_status_out[scgs_pkg::ST_INIT_DONE] = state_reg.init_done;
		resp_status_out[scgs_pkg::ST_CONNECTED] = state_reg.connected;
		resp_status_out[scgs_pkg::ST_ENCODER_ON] = state_reg.encoder_on;
		resp_status_out[scgs_pkg::ST_SERVO_ON] = state_reg.servo_on;
		resp_status_out[scgs_pkg::ST_PARAM_PENDING] =
			state_reg.param_pending;
		resp_status_out[scgs_pkg::ST_CMD_ERROR] = state_reg.cmd_error;
		resp_status_out[scgs_pkg::ST_SEQ_ERROR] = state_reg.seq_error;
		resp_status_out[scgs_pkg::ST_WDT_ALARM] = state_reg.wdt_alarm;
	end
endmodule : scgs_sequencer

// *** rtl/scgs_pkg.sv ***
package scgs_pkg;
	// Main command codes
	localparam logic [7:0] MAIN_NOP = 8'h00;
	localparam logic [7:0] MAIN_IDENTITY_READ = 8'h03;
	localparam logic [7:0] MAIN_CONFIG_APPLY = 8'h04;
	localparam logic [7:0] MAIN_ALARM_READ = 8'h05;
	localparam logic [7:0] MAIN_ALARM_CLEAR = 8'h06;
	localparam logic [7:0] MAIN_SYNC_SET = 8'h0d;
	localparam logic [7:0] MAIN_CONNECT = 8'h0e;
	localparam logic [7:0] MAIN_DISCONNECT = 8'h0f;
	localparam logic [7:0] MAIN_MEM_READ = 8'h1d;
	localparam logic [7:0] MAIN_MEM_WRITE = 8'h1e;
	localparam logic [7:0] MAIN_POS_SET = 8'h20;
	localparam logic [7:0] MAIN_BRAKE_ENGAGE = 8'h21;
	localparam logic [7:0] MAIN_BRAKE_RELEASE = 8'h22;
	localparam logic [7:0] MAIN_ENCODER_POWER_UP = 8'h23;
	localparam logic [7:0] MAIN_ENCODER_POWER_DOWN = 8'h24;
	localparam logic [7:0] MAIN_MONITOR_STATUS = 8'h30;
	localparam logic [7:0] MAIN_SERVO_ENABLE = 8'h31;
	localparam logic [7:0] MAIN_SERVO_DISABLE = 8'h32;
	localparam logic [7:0] MAIN_INTERPOLATE = 8'h34;
	localparam logic [7:0] MAIN_POSITIONING_MOVE = 8'h35;
	localparam logic [7:0] MAIN_FEED = 8'h36;
	localparam logic [7:0] MAIN_LATCHED_FEED = 8'h37;
	localparam logic [7:0] MAIN_LATCHED_POSITIONING = 8'h39;
	localparam logic [7:0] MAIN_ORIGIN_RETURN = 8'h3a;
	localparam logic [7:0] MAIN_VELOCITY_CONTROL = 8'h3c;
	localparam logic [7:0] MAIN_TORQUE_CONTROL = 8'h3d;
	localparam logic [7:0] MAIN_SERVO_PARAM_READ = 8'h40;
	localparam logic [7:0] MAIN_SERVO_PARAM_WRITE = 8'h41;

	// Sub command codes
	localparam logic [7:0] SUB_NOP = 8'h00;
	localparam logic [7:0] SUB_ALARM_READ = 8'h05;
	localparam logic [7:0] SUB_ALARM_CLEAR = 8'h06;
	localparam logic [7:0] SUB_MEM_READ = 8'h1d;
	localparam logic [7:0] SUB_MEM_WRITE = 8'h1e;
	localparam logic [7:0] SUB_MONITOR_STATUS = 8'h30;
	localparam logic [7:0] SUB_SERVO_PARAM_READ = 8'h40;
	localparam logic [7:0] SUB_SERVO_PARAM_WRITE = 8'h41;

	// Default watchdog span in communication cycles
	localparam int WDT_CYCLES_DEFAULT = 16;
	localparam int WDT_WIDTH = 16;

	// Response status bit positions
	localparam int ST_INIT_DONE = 0;
	localparam int ST_CONNECTED = 1;
	localparam int ST_ENCODER_ON = 2;
	localparam int ST_SERVO_ON = 3;
	localparam int ST_PARAM_PENDING = 4;
	localparam int ST_CMD_ERROR = 5;
	localparam int ST_SEQ_ERROR = 6;
	localparam int ST_WDT_ALARM = 7;
	localparam int ST_WIDTH = 8;

	typedef enum logic [1:0] {
		SCGS_CLASS_ALL,
		SCGS_CLASS_NOP_MON,
		SCGS_CLASS_NOP_ONLY,
		SCGS_CLASS_UNKNOWN
	} scgs_class_t;
endpackage : scgs_pkg

// *** rtl/scgs_decode_if.sv ***
`timescale 1ns/1ps
interface scgs_decode_if;
	logic [7:0] main_code;
	logic [7:0] sub_code;
	scgs_pkg::scgs_class_t main_class;
	logic sub_known;
	logic sub_allowed;

	modport requester (output main_code, output sub_code,
		input main_class, input sub_known, input sub_allowed);
	modport decoder (input main_code, input sub_code,
		output main_class, output sub_known, output sub_allowed);
endinterface : scgs_decode_if

// *** rtl/scgs_permit_decoder.sv ***
`timescale 1ns/1ps
module scgs_permit_decoder (
	scgs_decode_if.decoder dec
);
	always_comb begin
		unique case (dec.main_code)
			scgs_pkg::MAIN_NOP, scgs_pkg::MAIN_IDENTITY_READ,
			scgs_pkg::MAIN_MONITOR_STATUS, scgs_pkg::MAIN_SERVO_ENABLE,
			scgs_pkg::MAIN_SERVO_DISABLE, scgs_pkg::MAIN_INTERPOLATE,
			scgs_pkg::MAIN_POSITIONING_MOVE, scgs_pkg::MAIN_FEED,
			scgs_pkg::MAIN_LATCHED_FEED,
			scgs_pkg::MAIN_LATCHED_POSITIONING,
			scgs_pkg::MAIN_ORIGIN_RETURN,
			scgs_pkg::MAIN_VELOCITY_CONTROL,
			scgs_pkg::MAIN_TORQUE_CONTROL: begin
				dec.main_class = scgs_pkg::SCGS_CLASS_ALL;
			end
			scgs_pkg::MAIN_CONFIG_APPLY, scgs_pkg::MAIN_ALARM_READ,
			scgs_pkg::MAIN_ALARM_CLEAR, scgs_pkg::MAIN_SYNC_SET,
			scgs_pkg::MAIN_MEM_READ, scgs_pkg::MAIN_MEM_WRITE,
			scgs_pkg::MAIN_POS_SET, scgs_pkg::MAIN_BRAKE_ENGAGE,
			scgs_pkg::MAIN_BRAKE_RELEASE,
			scgs_pkg::MAIN_ENCODER_POWER_UP,
			scgs_pkg::MAIN_ENCODER_POWER_DOWN,
			scgs_pkg::MAIN_SERVO_PARAM_READ,
			scgs_pkg::MAIN_SERVO_PARAM_WRITE: begin
				dec.main_class = scgs_pkg::SCGS_CLASS_NOP_MON;
			end
			scgs_pkg::MAIN_CONNECT, scgs_pkg::MAIN_DISCONNECT: begin
				dec.main_class = scgs_pkg::SCGS_CLASS_NOP_ONLY;
			end
			default: begin
				dec.main_class = scgs_pkg::SCGS_CLASS_UNKNOWN;
			end
		endcase
	end

	always_comb begin
		unique case (dec.sub_code)
			scgs_pkg::SUB_NOP, scgs_pkg::SUB_ALARM_READ,
			scgs_pkg::SUB_ALARM_CLEAR, scgs_pkg::SUB_MEM_READ,
			scgs_pkg::SUB_MEM_WRITE, scgs_pkg::SUB_MONITOR_STATUS,
			scgs_pkg::SUB_SERVO_PARAM_READ,
			scgs_pkg::SUB_SERVO_PARAM_WRITE: begin
				dec.sub_known = 1'b1;
			end
			default: begin
				dec.sub_known = 1'b0;
			end
		endcase
	end

	// Pairing table: a sub command only counts with a main that carries it
	always_comb begin
		unique case (dec.main_class)
			scgs_pkg::SCGS_CLASS_ALL: begin
				dec.sub_allowed = dec.sub_known;
			end
			scgs_pkg::SCGS_CLASS_NOP_MON: begin
				dec.sub_allowed = (dec.sub_code == scgs_pkg::SUB_NOP) ||
					(dec.sub_code == scgs_pkg::SUB_MONITOR_STATUS);
			end
			scgs_pkg::SCGS_CLASS_NOP_ONLY: begin
				dec.sub_allowed = (dec.sub_code == scgs_pkg::SUB_NOP);
			end
			scgs_pkg::SCGS_CLASS_UNKNOWN: begin
				dec.sub_allowed = 1'b0;
			end
		endcase
	end
endmodule : scgs_permit_decoder

// *** verif/scgs_seq_monitor.sv ***
`timescale 1ns/1ps
module scgs_seq_monitor (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] main_code_in,
	input wire logic [7:0] sub_code_in,
	input wire logic amp_managed_in,
	input wire logic resp_valid_out,
	input wire logic [7:0] resp_status_out,
	input wire logic sub_exec_out,
	input wire logic identity_read_out,
	input wire logic param_stage_out,
	input wire logic param_apply_out,
	input wire logic flash_store_out,
	input wire logic connected_out,
	input wire logic encoder_power_out,
	input wire logic servo_on_out,
	input wire logic wdt_alarm_out
);
	wire c = cmd_valid_in;
	wire [7:0] m = main_code_in;
	wire [7:0] s = sub_code_in;
	wire k = s inside {8'h00, 8'h05, 8'h06, 8'h1d, 8'h1e, 8'h30, 8'h40, 8'h41};
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////////
	resp_pulse_a: assert property (c |=> resp_valid_out)
		else $error("no response");
	resp_cause_a: assert property (!c |=> !resp_valid_out)
		else $error("stray response");
	link_nop_a: assert property (c && m inside {8'h0e, 8'h0f} && s != 8'h00
		|=> !sub_exec_out && resp_status_out[5]) else $error("link sub");
	mon_only_a: assert property (c && m inside {8'h04, 8'h05, 8'h06,
		8'h0d, 8'h1d, 8'h1e, [8'h20:8'h24], 8'h40, 8'h41}
		&& !(s inside {8'h00, 8'h30}) |=> !sub_exec_out && resp_status_out[5])
		else $error("limited sub");
	unknown_sub_a: assert property (c && !k
		|=> !sub_exec_out && resp_status_out[5]) else $error("bad sub");
	all_sub_a: assert property (c && k && m inside {8'h00, 8'h03, 8'h30,
		8'h31, 8'h32, [8'h34:8'h37], 8'h39, 8'h3a, 8'h3c, 8'h3d}
		|=> sub_exec_out && !resp_status_out[5]) else $error("sub dropped");
	connect_open_a: assert property (c && m == 8'h0e && s == 8'h00
		|=> connected_out && !wdt_alarm_out) else $error("no connect");
	enc_first_a: assert property (c && m == 8'h31 && !encoder_power_out
		|=> !servo_on_out && resp_status_out[6]) else $error("servo early");
	apply_cause_a: assert property (param_apply_out
		|-> $past(c) && $past(m) == 8'h04) else $error("stray apply");
	flash_path_a: assert property (flash_store_out
		|-> !param_stage_out && $past(amp_managed_in)) else $error("flash");
	wdt_drop_a: assert property ($rose(wdt_alarm_out)
		|-> !connected_out && !servo_on_out) else $error("wdt link");
	id_answer_a: assert property (c && m == 8'h03 && connected_out
		|=> identity_read_out) else $error("no identity");
endmodule : scgs_seq_monitor

bind scgs_sequencer scgs_seq_monitor u_mon (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
	.main_code_in(main_code_in), .sub_code_in(sub_code_in),
	.amp_managed_in(amp_managed_in), .resp_valid_out(resp_valid_out),
	.resp_status_out(resp_status_out), .sub_exec_out(sub_exec_out),
	.identity_read_out(identity_read_out),
	.param_stage_out(param_stage_out), .param_apply_out(param_apply_out),
	.flash_store_out(flash_store_out), .connected_out(connected_out),
	.encoder_power_out(encoder_power_out), .servo_on_out(servo_on_out),
	.wdt_alarm_out(wdt_alarm_out));

// *** verif/scgs_host_model.sv ***
`timescale 1ns/1ps
module scgs_host_model (
	input wire logic clk_in,
	output logic cycle_tick_out,
	output logic cmd_valid_out,
	output logic [7:0] main_out,
	output logic [7:0] sub_out
);
	initial begin
		cycle_tick_out = 1'b0;
		cmd_valid_out = 1'b0;
		main_out = 8'h00;
		sub_out = 8'h00;
	end
	////////////////////////////////////////////////////////////////////
	// Codes are inverted when idle so a stale value never looks valid
	task send(input logic [7:0] mc, input logic [7:0] sc);
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		main_out = mc;
		sub_out = sc;
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		main_out = ~mc;
		sub_out = ~sc;
		// Return while the one-cycle answer pulses still stand
	endtask : send
	task ticks(input int n);
		repeat (n) begin
			@(negedge clk_in);
			cycle_tick_out = 1'b1;
			@(negedge clk_in);
			cycle_tick_out = 1'b0;
		end
		@(negedge clk_in);
	endtask : ticks
	task relink;
		send(8'h0f, 8'h00);
		ticks(3);
		send(8'h0e, 8'h00);
	endtask : relink
endmodule : scgs_host_model

// *** verif/servo_command_gate_sequencer_test.sv ***
`timescale 1ns/1ps
module servo_command_gate_sequencer_test;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic init = 1'b0;
	logic amp = 1'b0;
	logic tick, cv, rv, mx, sx, idr, prd, pst, pap, fls, con, enc, svo, wdt;
	logic [7:0] mc, sc, rm, rs, st;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [7:0] mains [28] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0d,
		8'h0e, 8'h0f, 8'h1d, 8'h1e, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30,
		8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3a, 8'h3c, 8'h3d,
		8'h40, 8'h41};
	logic [7:0] subs [9] = '{8'h00, 8'h05, 8'h06, 8'h1d, 8'h1e, 8'h30,
		8'h40, 8'h41, 8'h07};
	always #2.5 clk_in = ~clk_in;
	scgs_host_model u_host (.clk_in(clk_in), .cycle_tick_out(tick),
		.cmd_valid_out(cv), .main_out(mc), .sub_out(sc));
	scgs_sequencer #(.WDT_CYCLES(3)) u_dut (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .cycle_tick_in(tick), .cmd_valid_in(cv),
		.main_code_in(mc), .sub_code_in(sc), .init_done_in(init),
		.amp_managed_in(amp), .resp_valid_out(rv), .resp_main_out(rm),
		.resp_sub_out(rs), .resp_status_out(st), .main_exec_out(mx),
		.sub_exec_out(sx), .identity_read_out(idr), .param_read_out(prd),
		.param_stage_out(pst), .param_apply_out(pap), .flash_store_out(fls),
		.connected_out(con), .encoder_power_out(enc), .servo_on_out(svo),
		.wdt_alarm_out(wdt));
	////////////////////////////////////////////////////////////////////
	task chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task stop_test;
		$display("errors=%0d checks=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	function automatic logic allowed(input logic [7:0] m, input logic [7:0] s);
		if (!(s inside {8'h00, 8'h05, 8'h06, 8'h1d, 8'h1e, 8'h30, 8'h40, 8'h41}))
			return 1'b0;
		if (m inside {8'h0e, 8'h0f})
			return s == 8'h00;
		if (m inside {8'h04, 8'h05, 8'h06, 8'h0d, 8'h1d, 8'h1e, 8'h20, 8'h21,
			8'h22, 8'h23, 8'h24, 8'h40, 8'h41})
			return s inside {8'h00, 8'h30};
		return 1'b1;
	endfunction : allowed
	// Host-managed flow, including servo enable tried before encoder power
	task t_session;
		u_host.send(8'h03, 8'h00);
		chk(idr === 1'b0 && mx === 1'b0 && st[6] === 1'b1, "no link");
		u_host.send(8'h00, 8'h00);
		chk(st[0] === 1'b1 && rv === 1'b1, "init");
		u_host.relink();
		chk(con === 1'b1 && mx === 1'b1 && st[1] === 1'b1, "connect");
		u_host.send(8'h03, 8'h00);
		chk(idr === 1'b1 && rm === 8'h03, "identity");
		u_host.send(8'h40, 8'h00);
		chk(prd === 1'b1, "param read");
		u_host.send(8'h41, 8'h00);
		chk(pst === 1'b1 && st[4] === 1'b1 && pap === 1'b0, "stage");
		u_host.send(8'h04, 8'h00);
		chk(pap === 1'b1 && st[4] === 1'b0, "apply");
		u_host.send(8'h31, 8'h00);
		chk(svo === 1'b0 && st[6] === 1'b1, "servo early");
		u_host.send(8'h23, 8'h00);
		chk(enc === 1'b1 && st[2] === 1'b1, "encoder");
		u_host.send(8'h31, 8'h00);
		chk(svo === 1'b1 && st[3] === 1'b1, "servo on");
		u_host.send(8'h35, 8'h00);
		chk(mx === 1'b1 && st[6] === 1'b0, "move");
		u_host.send(8'h32, 8'h00);
		chk(svo === 1'b0, "servo off");
		u_host.send(8'h0f, 8'h00);
		chk(con === 1'b0 && enc === 1'b1, "release");
	endtask : t_session
	task t_flash;
		amp = 1'b1;
		u_host.relink();
		u_host.send(8'h41, 8'h00);
		chk(fls === 1'b1 && pst === 1'b0 && st[4] === 1'b0, "flash");
		u_host.send(8'h0f, 8'h00);
		amp = 1'b0;
	endtask : t_flash
	task t_watchdog;
		u_host.relink();
		u_host.ticks(2);
		chk(wdt === 1'b0 && con === 1'b1, "wdt early");
		u_host.ticks(1);
		chk(wdt === 1'b1 && con === 1'b0 && st[7] === 1'b1, "wdt trip");
		u_host.send(8'h0e, 8'h00);
		chk(wdt === 1'b0 && con === 1'b1 && st[7] === 1'b0, "wdt clear");
	endtask : t_watchdog
	// Every main code against every sub code plus one undefined sub
	task t_pairing;
		foreach (mains[i])
			foreach (subs[j]) begin
				u_host.send(mains[i], subs[j]);
				chk(sx === allowed(mains[i], subs[j]), "pairing");
				chk(st[5] === !allowed(mains[i], subs[j]), "cmd error");
				chk(rv === 1'b1 && rs === subs[j], "echo");
			end
		u_host.send(8'h07, 8'h00);
		chk(mx === 1'b0 && sx === 1'b0 && st[5] === 1'b1 &&
			st[6] === 1'b0, "unknown main");
	endtask : t_pairing
	////////////////////////////////////////////////////////////////////
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		repeat (5) @(negedge clk_in);
		sys_rst_in = 1'b0;
		chk(con === 1'b0 && rv === 1'b0 && st[0] === 1'b0, "reset");
		init = 1'b1;
		t_session();
		t_flash();
		t_watchdog();
		t_pairing();
		stop_test();
	end
endmodule : servo_command_gate_sequencer_test
